//--- shared/pin_mux_pkg.sv
// constants shared by the port b/c/d override logic
// assumes a 100 mhz core clock
package pin_mux_pkg;
    // clock and spike filter timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int SPIKE_FILTER_NS = 50;
    localparam int SPIKE_CYCLES   =
        (SPIKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] SPIKE_LAST = 3'(SPIKE_CYCLES - 1);

    // sampled pin vector: {port b, port c, port d}
    localparam int SAMPLE_W = 24;
    localparam int PB_LSB   = 16;
    localparam int PC_LSB   = 8;
    localparam int PD_LSB   = 0;
    // scl (d0) and sda (d1) get the spike filter
    localparam logic [23:0] FILTER_MASK = 24'h000003;

    // port b spi bit positions
    localparam int SS_BIT   = 0;
    localparam int SCK_BIT  = 1;
    localparam int MOSI_BIT = 2;
    localparam int MISO_BIT = 3;

    // port d bit positions
    localparam int SCL_BIT  = 0;
    localparam int SDA_BIT  = 1;
    localparam int RX_BIT   = 2;
    localparam int TX_BIT   = 3;
    localparam int CAP_BIT  = 4;
    localparam int XCK_BIT  = 5;
    localparam int TM1_BIT  = 6;
    localparam int TM0_BIT  = 7;

    // address takeover limit per port c bit, bit 7 in the top field
    localparam logic [23:0] ADR_LIMIT = {3'h1, 3'h2, 3'h3, 3'h4,
                                         3'h5, 3'h6, 3'h7, 3'h7};

    // reset values
    localparam logic [7:0]  RST_BYTE   = 8'h00;
    localparam logic [23:0] RST_SAMPLE = 24'h000000;
endpackage : pin_mux_pkg

//--- shared/pin_sample_if.sv
// carrier between the override top and its pin sampler
// assumes both ends run on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface pin_sample_if;
    import pin_mux_pkg::*;
    logic [SAMPLE_W-1:0] raw;
    logic [SAMPLE_W-1:0] clean;
    // the sampler turns raw pins into clean levels
    modport sampler (input raw, output clean);
    // the override logic supplies pins and reads levels
    modport user (output raw, input clean);
endinterface : pin_sample_if
`default_nettype wire

//--- hdl/pin_sampler.sv
// three-flop pin synchroniser with optional spike filter
// assumes pins are asynchronous to core_clk_i
`timescale 1ns/1ps
`default_nettype none
module pin_sampler
    import pin_mux_pkg::*;
(
    input  wire logic   core_clk_i,
    input  wire logic   sys_rst_i,
    pin_sample_if.sampler pins
);
    logic [SAMPLE_W-1:0] stage1;
    logic [SAMPLE_W-1:0] stage2;
    logic [SAMPLE_W-1:0] stage3;
    logic [SAMPLE_W-1:0] level;

    // three flops; stage1 feeds stage2 only
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stage1 <= RST_SAMPLE;
            stage2 <= RST_SAMPLE;
            stage3 <= RST_SAMPLE;
        end else begin
            stage1 <= pins.raw;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // accept a change once stage2 and stage3 agree long enough
    for (genvar i = 0; i < SAMPLE_W; i++) begin : g_bit
        logic [2:0] hold;
        always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                hold     <= 3'h0;
                level[i] <= 1'h0;
            end else if (stage2[i] != stage3[i] || stage3[i] == level[i]) begin
                hold <= 3'h0;
            end else if (!FILTER_MASK[i] || hold == SPIKE_LAST) begin
                hold     <= 3'h0;
                level[i] <= stage3[i];
            end else begin
                hold <= hold + 3'h1;
            end
        end
    end

    assign pins.clean = level;
endmodule : pin_sampler
`default_nettype wire

//--- hdl/port_bcd_alternate_override.sv
// override logic for ports b, c and d alternate functions
// assumes port registers and peripheral controls are on core_clk_i
// and that the pad ring resolves pullup, oe and out into the wire
//
// Overview of operation
// - spi slave forces select pin b0 to input, direction bit ignored
// - slave spi active only while select pin held low
// - master select pin follows its direction bit; pull-up follows port bit
// - compare outputs override value on b7..b4; pull-up and direction untouched
// - miso carries master input/slave output; mosi master output/slave input
// - b3..b0 overrides gated by spi enable and role; value never on select
// - port b input buffer forced on when pin-change mask and group enabled
// - c7..c4 drive address 15..12 when mask below 1..4, no pull-up
// - c3, c2 take address below mask 5, 6; c1, c0 below 7
// - port c bits 7..0 carry address bits 15..8 in order
// - d5 serial clock output when direction set, only in synchronous mode
// - serial transmitter enabled forces d3 output with transmit data
// - serial receiver forces d2 input; pull-up follows port bit
// - two-wire enable detaches d1 as sda, filters 50ns spikes, pulls low
// - d7, d6 feed timer count inputs; d4 feeds capture trigger
// - d3..d0 also serve as external interrupt inputs 3..0
// - miso input in master, mosi and sck input in slave
`timescale 1ns/1ps
`default_nettype none
module port_bcd_alternate_override
    import pin_mux_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       sys_rst_i,
    // pins and port registers
    input  wire logic [7:0] pin_b_i,
    input  wire logic [7:0] pin_c_i,
    input  wire logic [7:0] pin_d_i,
    input  wire logic [7:0] port_b_i,
    input  wire logic [7:0] port_c_i,
    input  wire logic [7:0] port_d_i,
    input  wire logic [7:0] dir_b_i,
    input  wire logic [7:0] dir_c_i,
    input  wire logic [7:0] dir_d_i,
    input  wire logic       pull_up_disable_all_i,
    input  wire logic       sleep_input_off_i,
    // spi unit
    input  wire logic       spi_enable_bit_i,
    input  wire logic       spi_master_select_i,
    input  wire logic       spi_slave_out_i,
    input  wire logic       spi_master_out_i,
    input  wire logic       spi_sck_out_i,
    // timers, b7 shares two compare outputs
    input  wire logic [3:0] compare_en_i,
    input  wire logic [3:0] compare_val_i,
    input  wire logic       timer1_compare_c_en_i,
    input  wire logic       timer1_compare_c_out_i,
    // pin change group
    input  wire logic [7:0] pin_change_mask_i,
    input  wire logic       pin_change_group0_enable_i,
    // external memory
    input  wire logic       ext_mem_enable_i,
    input  wire logic [2:0] ext_mem_high_mask_i,
    input  wire logic [7:0] ext_addr_high_i,
    // second serial unit
    input  wire logic       serial1_sync_mode_i,
    input  wire logic       serial1_clk_out_i,
    input  wire logic       serial1_tx_en_i,
    input  wire logic       serial1_tx_data_i,
    input  wire logic       serial1_rx_en_i,
    // two-wire unit, 1 on the low inputs pulls the line low
    input  wire logic       two_wire_enable_i,
    input  wire logic       two_wire_sda_low_i,
    input  wire logic       two_wire_scl_low_i,
    input  wire logic [3:0] ext_irq_en_i,
    // pad controls
    output logic [7:0]      pb_pullup_o,
    output logic [7:0]      pb_oe_o,
    output logic [7:0]      pb_out_o,
    output logic [7:0]      pb_ie_o,
    output logic [7:0]      pc_pullup_o,
    output logic [7:0]      pc_oe_o,
    output logic [7:0]      pc_out_o,
    output logic [7:0]      pc_ie_o,
    output logic [7:0]      pd_pullup_o,
    output logic [7:0]      pd_oe_o,
    output logic [7:0]      pd_out_o,
    output logic [7:0]      pd_ie_o,
    // sampled levels back to the port and peripherals
    output logic [7:0]      pin_b_level_o,
    output logic [7:0]      pin_c_level_o,
    output logic [7:0]      pin_d_level_o,
    output logic            spi_master_in_o,
    output logic            spi_slave_in_o,
    output logic            spi_sck_in_o,
    output logic            spi_slave_active_o,
    output logic [7:0]      pin_change_in_o,
    output logic            timer0_count_input_o,
    output logic            timer1_count_input_o,
    output logic            capture1_trigger_input_o,
    output logic            serial1_ext_clock_in_o,
    output logic            serial1_rx_in_o,
    output logic [3:0]      ext_irq_in_o,
    output logic            sda_in_o,
    output logic            scl_in_o
);
    // one override slot: enable picks value over the normal bit
    function automatic logic [7:0] merge8(input logic [7:0] oe,
                                          input logic [7:0] ov,
                                          input logic [7:0] base);
        return (oe & ov) | (~oe & base);
    endfunction : merge8

    pin_sample_if pins ();
    logic [7:0] lvl_b;
    logic [7:0] lvl_c;
    logic [7:0] lvl_d;
    logic       spi_master;
    logic       spi_slave;
    logic       xck_drive;
    logic [7:0] nopud;
    logic [7:0] norm_ie;
    logic [7:0] c_take;
    logic [7:0] b_pull;
    logic [7:0] b_vsel;
    logic [7:0] b_vval;
    logic [7:0] b_iesel;
    logic [7:0] d_pull;
    logic [7:0] d_dsel;
    logic [7:0] d_dval;
    logic [7:0] d_vsel;
    logic [7:0] d_vval;
    logic [7:0] next_pb_ie;
    logic [7:0] next_pc_ie;
    logic [7:0] next_pd_ie;

    // pins into the synchroniser
    assign pins.raw = {pin_b_i, pin_c_i, pin_d_i};
    assign lvl_b    = pins.clean[PB_LSB +: 8];
    assign lvl_c    = pins.clean[PC_LSB +: 8];
    assign lvl_d    = pins.clean[PD_LSB +: 8];

    pin_sampler u_sampler (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .pins       (pins.sampler)
    );

    // shared terms
    assign spi_master = spi_enable_bit_i & spi_master_select_i;
    assign spi_slave  = spi_enable_bit_i & ~spi_master_select_i;
    assign xck_drive  = serial1_sync_mode_i & dir_d_i[XCK_BIT];
    assign nopud      = {8{~pull_up_disable_all_i}};
    assign norm_ie    = {8{~sleep_input_off_i}};

    // port b override slots
    always_comb begin
        b_pull = {4'h0, spi_master, spi_slave, spi_slave, spi_slave};
        b_vsel = {compare_en_i[3] | timer1_compare_c_en_i,
                  compare_en_i[2:0],
                  spi_slave, spi_master, spi_master, 1'h0};
        b_vval = {compare_en_i[3] ? compare_val_i[3] : timer1_compare_c_out_i,
                  compare_val_i[2:0],
                  spi_slave_out_i, spi_master_out_i, spi_sck_out_i,
                  1'h0};
        b_iesel = pin_change_mask_i & {8{pin_change_group0_enable_i}};
    end

    // port c address takeover per bit
    for (genvar i = 0; i < 8; i++) begin : g_addr
        assign c_take[i] = ext_mem_enable_i &
                           (ext_mem_high_mask_i < ADR_LIMIT[i*3 +: 3]);
    end

    // port d override slots
    always_comb begin
        d_pull = {4'h0, serial1_tx_en_i, serial1_rx_en_i,
                  two_wire_enable_i, two_wire_enable_i};
        d_dsel = {2'h0, xck_drive, 1'h0, serial1_tx_en_i, serial1_rx_en_i,
                  two_wire_enable_i, two_wire_enable_i};
        d_dval = {2'h0, 1'h1, 1'h0, 1'h1, 1'h0,
                  two_wire_sda_low_i, two_wire_scl_low_i};
        d_vsel = {2'h0, xck_drive, 1'h0, serial1_tx_en_i, 1'h0,
                  two_wire_enable_i, two_wire_enable_i};
        d_vval = {2'h0, serial1_clk_out_i, 1'h0, serial1_tx_data_i,
                  3'h0};
    end

    // input enables, shared by pad outputs and peripheral inputs
    assign next_pb_ie = merge8(b_iesel, 8'hff, norm_ie);
    assign next_pc_ie = norm_ie;
    assign next_pd_ie = merge8({4'h0, ext_irq_en_i}, 8'hff, norm_ie);

    // port b pads
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pb_pullup_o <= RST_BYTE;
            pb_oe_o     <= RST_BYTE;
            pb_out_o    <= RST_BYTE;
            pb_ie_o     <= RST_BYTE;
        end else begin
            pb_pullup_o <= merge8(b_pull, port_b_i & nopud,
                                  port_b_i & ~dir_b_i & nopud);
            pb_oe_o     <= merge8(b_pull, 8'h00, dir_b_i);
            pb_out_o    <= merge8(b_vsel, b_vval, port_b_i);
            pb_ie_o     <= next_pb_ie;
        end
    end

    // port c pads
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pc_pullup_o <= RST_BYTE;
            pc_oe_o     <= RST_BYTE;
            pc_out_o    <= RST_BYTE;
            pc_ie_o     <= RST_BYTE;
        end else begin
            pc_pullup_o <= merge8(c_take, 8'h00,
                                  port_c_i & ~dir_c_i & nopud);
            pc_oe_o     <= merge8(c_take, 8'hff, dir_c_i);
            pc_out_o    <= merge8(c_take, ext_addr_high_i, port_c_i);
            pc_ie_o     <= next_pc_ie;
        end
    end

    // port d pads
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pd_pullup_o <= RST_BYTE;
            pd_oe_o     <= RST_BYTE;
            pd_out_o    <= RST_BYTE;
            pd_ie_o     <= RST_BYTE;
        end else begin
            pd_pullup_o <= merge8(d_pull, {5'h0, port_d_i[2:0]} & nopud,
                                  port_d_i & ~dir_d_i & nopud);
            pd_oe_o     <= merge8(d_dsel, d_dval, dir_d_i);
            pd_out_o    <= merge8(d_vsel, d_vval, port_d_i);
            pd_ie_o     <= next_pd_ie;
        end
    end

    // levels back to port registers, gated by input enable
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_b_level_o <= RST_BYTE;
            pin_c_level_o <= RST_BYTE;
            pin_d_level_o <= RST_BYTE;
        end else begin
            pin_b_level_o <= lvl_b & next_pb_ie;
            pin_c_level_o <= lvl_c & next_pc_ie;
            pin_d_level_o <= lvl_d & next_pd_ie;
        end
    end

    // spi inputs and slave activity
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            spi_master_in_o    <= 1'h0;
            spi_slave_in_o     <= 1'h0;
            spi_sck_in_o       <= 1'h0;
            spi_slave_active_o <= 1'h0;
        end else begin
            spi_master_in_o    <= lvl_b[MISO_BIT] & next_pb_ie[MISO_BIT];
            spi_slave_in_o     <= lvl_b[MOSI_BIT] & next_pb_ie[MOSI_BIT];
            spi_sck_in_o       <= lvl_b[SCK_BIT] & next_pb_ie[SCK_BIT];
            spi_slave_active_o <= spi_slave & ~lvl_b[SS_BIT];
        end
    end

    // timer, serial, interrupt and two-wire inputs
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_change_in_o          <= RST_BYTE;
            timer0_count_input_o     <= 1'h0;
            timer1_count_input_o     <= 1'h0;
            capture1_trigger_input_o <= 1'h0;
            serial1_ext_clock_in_o   <= 1'h0;
            serial1_rx_in_o          <= 1'h0;
            ext_irq_in_o             <= 4'h0;
            sda_in_o                 <= 1'h0;
            scl_in_o                 <= 1'h0;
        end else begin
            pin_change_in_o          <= lvl_b & next_pb_ie;
            timer0_count_input_o     <= lvl_d[TM0_BIT] & norm_ie[TM0_BIT];
            timer1_count_input_o     <= lvl_d[TM1_BIT] & norm_ie[TM1_BIT];
            capture1_trigger_input_o <= lvl_d[CAP_BIT] & norm_ie[CAP_BIT];
            serial1_ext_clock_in_o   <= lvl_d[XCK_BIT] & serial1_sync_mode_i;
            serial1_rx_in_o          <= lvl_d[RX_BIT] & next_pd_ie[RX_BIT];
            ext_irq_in_o             <= lvl_d[3:0] & next_pd_ie[3:0];
            sda_in_o                 <= lvl_d[SDA_BIT] & two_wire_enable_i;
            scl_in_o                 <= lvl_d[SCL_BIT] & two_wire_enable_i;
        end
    end

    // checks on the registered pad controls and slave activity
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_ss_slave_input: assert property (
        spi_slave |=> !pb_oe_o[SS_BIT])
        else $error("select pin driven in spi slave role");

    a_ss_master_dir: assert property (
        spi_master |=> pb_oe_o[SS_BIT] == $past(dir_b_i[SS_BIT]))
        else $error("select pin direction ignores its bit in master role");

    a_slave_active: assert property (
        spi_slave_active_o |-> $past(spi_slave))
        else $error("slave active outside slave role");

    a_compare_value: assert property (
        compare_en_i[1] |=> pb_out_o[5] == $past(compare_val_i[1])
                            && pb_oe_o[5] == $past(dir_b_i[5]))
        else $error("compare output not on b5 or direction touched");

    a_miso_master_in: assert property (
        spi_master |=> !pb_oe_o[MISO_BIT] && !pb_oe_o[MOSI_BIT] == !$past(dir_b_i[MOSI_BIT]))
        else $error("miso not input in master role");

    a_ss_value_kept: assert property (
        spi_enable_bit_i |=> pb_out_o[SS_BIT] == $past(port_b_i[SS_BIT]))
        else $error("select pin output value overridden");

    a_pcint_ie: assert property (
        pin_change_group0_enable_i && pin_change_mask_i[2] |=> pb_ie_o[2])
        else $error("pin change input buffer not forced on");

    a_addr_c7: assert property (
        ext_mem_enable_i && ext_mem_high_mask_i == 3'h0
        |=> pc_oe_o[7] && !pc_pullup_o[7] && pc_out_o[7] == $past(ext_addr_high_i[7]))
        else $error("c7 not taken over as address 15");

    a_addr_c0_free: assert property (
        ext_mem_enable_i && ext_mem_high_mask_i == 3'h7
        |=> pc_out_o[0] == $past(port_c_i[0]))
        else $error("c0 taken over at full mask");

    a_tx_forced: assert property (
        serial1_tx_en_i |=> pd_oe_o[TX_BIT] && pd_out_o[TX_BIT] == $past(serial1_tx_data_i))
        else $error("transmit pin not forced to output");

    a_rx_forced: assert property (
        serial1_rx_en_i && !two_wire_enable_i
        |=> !pd_oe_o[RX_BIT] && pd_pullup_o[RX_BIT] == $past(port_d_i[RX_BIT] & nopud[RX_BIT]))
        else $error("receive pin not forced to input");

    a_sda_pull_low: assert property (
        two_wire_enable_i |=> !pd_out_o[SDA_BIT]
                              && pd_oe_o[SDA_BIT] == $past(two_wire_sda_low_i)
                              && pd_pullup_o[SDA_BIT] == $past(port_d_i[SDA_BIT] & nopud[1]))
        else $error("sda drives high");

    a_pud_all: assert property (
        pull_up_disable_all_i |=> pb_pullup_o == 8'h00 && pc_pullup_o == 8'h00
                                  && pd_pullup_o == 8'h00)
        else $error("pull-up active under global disable");

    c_slave_select: cover property (spi_slave ##1 spi_slave_active_o);
    c_addr_all: cover property (ext_mem_enable_i && ext_mem_high_mask_i == 3'h0
                                ##1 pc_oe_o == 8'hff);
    c_tx_forced: cover property (serial1_tx_en_i && !dir_d_i[TX_BIT] ##1 pd_oe_o[TX_BIT]);
    c_two_wire: cover property (two_wire_enable_i && two_wire_sda_low_i ##1 pd_oe_o[SDA_BIT]);
endmodule : port_bcd_alternate_override
`default_nettype wire

//--- verification/pad_partner.sv
// pad wire model standing at the far side of the override block
// assumes pad controls come from the block on the same core clock
`timescale 1ns/1ps
`default_nettype none
module pad_partner (
    input  wire logic        core_clk_i,
    input  wire logic [23:0] oe_i,
    input  wire logic [23:0] out_i,
    input  wire logic [23:0] pullup_i,
    input  wire logic [23:0] ext_en_i,
    input  wire logic [23:0] ext_val_i,
    output logic [23:0]      pin_o
);
    logic [23:0] last;
    // remember the wire so an undriven pin shows junk, not a stale level
    always_ff @(posedge core_clk_i) begin
        last <= pin_o;
    end
    // pad drive wins, then the outside driver, then the pull-up
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            if (oe_i[i]) begin
                pin_o[i] = out_i[i]; // open drain data line only drives 0
            end else if (ext_en_i[i]) begin
                pin_o[i] = ext_val_i[i];
            end else begin
                pin_o[i] = pullup_i[i] | ~last[i];
            end
        end
    end
endmodule : pad_partner
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the port b/c/d override block
// assumes the pad model resolves every pin from block and bench drive
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic core_clk_i, sys_rst_i, pull_up_disable_all_i, sleep_input_off_i, spi_enable_bit_i;
    logic spi_master_select_i, spi_slave_out_i, spi_master_out_i, spi_sck_out_i;
    logic timer1_compare_c_en_i, timer1_compare_c_out_i, pin_change_group0_enable_i;
    logic ext_mem_enable_i, serial1_sync_mode_i, serial1_clk_out_i, serial1_tx_en_i;
    logic serial1_tx_data_i, serial1_rx_en_i, two_wire_enable_i, two_wire_sda_low_i;
    logic two_wire_scl_low_i, spi_slave_active_o, sda_in_o;
    logic [7:0] port_b_i, port_c_i, port_d_i, dir_b_i, dir_c_i, dir_d_i, pin_b_i, pin_c_i;
    logic [7:0] pin_d_i, pin_change_mask_i, ext_addr_high_i, pb_pullup_o, pb_oe_o, pb_out_o;
    logic [7:0] pb_ie_o, pc_pullup_o, pc_oe_o, pc_out_o, pc_ie_o, pd_pullup_o, pd_oe_o;
    logic [7:0] pd_out_o, pd_ie_o, pin_b_level_o, pin_c_level_o, pin_d_level_o;
    logic [3:0] compare_en_i, compare_val_i, ext_irq_en_i;
    logic [2:0] ext_mem_high_mask_i;
    logic [23:0] pins, ext_val;
    logic [7:0] eu [3], eo [3], ev [3], ei [3];
    logic [127:0] r;
    logic [20:0] sd;
    logic ok;
    int error_cnt = 0, comparisons = 0, seed = 32667;

    port_bcd_alternate_override port_bcd_alternate_override_i (
        .core_clk_i, .sys_rst_i, .pin_b_i, .pin_c_i, .pin_d_i, .port_b_i, .port_c_i,
        .port_d_i, .dir_b_i, .dir_c_i, .dir_d_i, .pull_up_disable_all_i, .sleep_input_off_i,
        .spi_enable_bit_i, .spi_master_select_i, .spi_slave_out_i, .spi_master_out_i,
        .spi_sck_out_i, .compare_en_i, .compare_val_i, .timer1_compare_c_en_i,
        .timer1_compare_c_out_i, .pin_change_mask_i, .pin_change_group0_enable_i,
        .ext_mem_enable_i, .ext_mem_high_mask_i, .ext_addr_high_i, .serial1_sync_mode_i,
        .serial1_clk_out_i, .serial1_tx_en_i, .serial1_tx_data_i, .serial1_rx_en_i,
        .two_wire_enable_i, .two_wire_sda_low_i, .two_wire_scl_low_i, .ext_irq_en_i,
        .pb_pullup_o, .pb_oe_o, .pb_out_o, .pb_ie_o, .pc_pullup_o, .pc_oe_o, .pc_out_o,
        .pc_ie_o, .pd_pullup_o, .pd_oe_o, .pd_out_o, .pd_ie_o, .pin_b_level_o,
        .pin_c_level_o, .pin_d_level_o, .spi_master_in_o(sd[4]), .spi_slave_in_o(sd[3]),
        .spi_sck_in_o(sd[2]), .spi_slave_active_o, .pin_change_in_o(sd[20:13]),
        .timer0_count_input_o(sd[12]), .timer1_count_input_o(sd[11]),
        .capture1_trigger_input_o(sd[9]), .serial1_ext_clock_in_o(sd[10]),
        .serial1_rx_in_o(sd[1]), .ext_irq_in_o(sd[8:5]), .sda_in_o, .scl_in_o(sd[0]));

    pad_partner pad_partner_i (
        .core_clk_i, .oe_i({pb_oe_o, pc_oe_o, pd_oe_o}), .out_i({pb_out_o, pc_out_o, pd_out_o}),
        .pullup_i({pb_pullup_o, pc_pullup_o, pd_pullup_o}), .ext_en_i(24'hffffff),
        .ext_val_i(ext_val), .pin_o(pins));
    assign {pin_b_i, pin_c_i, pin_d_i} = pins;
    assign ok = ~pull_up_disable_all_i;

    // reference pad controls from the current inputs
    always_comb begin
        eu = '{port_b_i & ~dir_b_i & {8{ok}}, port_c_i & ~dir_c_i & {8{ok}},
               port_d_i & ~dir_d_i & {8{ok}}};
        eo = '{dir_b_i, dir_c_i, dir_d_i};
        ev = '{port_b_i, port_c_i, port_d_i};
        ei = '{{8{~sleep_input_off_i}} | (pin_change_mask_i & {8{pin_change_group0_enable_i}}),
               {8{~sleep_input_off_i}}, {8{~sleep_input_off_i}} | {4'h0, ext_irq_en_i}};
        if (compare_en_i[3] | timer1_compare_c_en_i) begin
            ev[0][7] = compare_en_i[3] ? compare_val_i[3] : timer1_compare_c_out_i;
        end
        for (int i = 0; i < 8; i++) begin
            if (i > 3 && i < 7 && compare_en_i[i-4]) begin
                ev[0][i] = compare_val_i[i-4];
            end
            if (spi_enable_bit_i && i < 4 && ((i == 3) == spi_master_select_i)) begin
                eu[0][i] = port_b_i[i] & ok;
                eo[0][i] = 1'b0;
            end
            if (ext_mem_enable_i && int'(ext_mem_high_mask_i) < ((i < 2) ? 7 : 8 - i)) begin
                eu[1][i] = 1'b0;
                eo[1][i] = 1'b1;
                ev[1][i] = ext_addr_high_i[i];
            end
        end
        if (spi_enable_bit_i && spi_master_select_i) begin
            ev[0][2] = spi_master_out_i;
            ev[0][1] = spi_sck_out_i;
        end else if (spi_enable_bit_i) begin
            ev[0][3] = spi_slave_out_i;
        end
        if (serial1_sync_mode_i & dir_d_i[5]) begin
            eo[2][5] = 1'b1;
            ev[2][5] = serial1_clk_out_i;
        end
        if (serial1_tx_en_i) begin
            eu[2][3] = 1'b0;
            eo[2][3] = 1'b1;
            ev[2][3] = serial1_tx_data_i;
        end
        if (serial1_rx_en_i) begin
            eu[2][2] = port_d_i[2] & ok;
            eo[2][2] = 1'b0;
        end
        if (two_wire_enable_i) begin
            eu[2][1:0] = port_d_i[1:0] & {2{ok}};
            eo[2][1:0] = {two_wire_sda_low_i, two_wire_scl_low_i};
            ev[2][1:0] = 2'b00;
        end
    end

    // free-running core clock
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic apply(input logic [121:0] v);
        {sleep_input_off_i, pull_up_disable_all_i, spi_enable_bit_i, spi_master_select_i,
         spi_slave_out_i, spi_master_out_i, spi_sck_out_i, timer1_compare_c_en_i,
         timer1_compare_c_out_i, pin_change_group0_enable_i, ext_mem_enable_i,
         serial1_sync_mode_i, serial1_clk_out_i, serial1_tx_en_i, serial1_tx_data_i,
         serial1_rx_en_i, two_wire_enable_i, two_wire_sda_low_i, two_wire_scl_low_i,
         port_b_i, port_c_i, port_d_i, dir_b_i, dir_c_i, dir_d_i, pin_change_mask_i,
         ext_addr_high_i, compare_en_i, compare_val_i, ext_irq_en_i, ext_mem_high_mask_i,
         ext_val} <= v;
    endtask : apply

    task automatic test_done();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    // watchdog against a hung run
    initial begin
        #200000;
        error_cnt++;
        test_done();
    end

    // random pad vectors, settled level checks, then the data line spike filter
    initial begin
        sys_rst_i = 1'b1;
        apply('0);
        repeat (12) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        for (int n = 0; n < 300; n++) begin
            @(posedge core_clk_i);
            r = {$random(seed), $random(seed), $random(seed), $random(seed)};
            if (n % 4 == 0) r[121] = 1'b0;
            apply(r[121:0]);
            @(posedge core_clk_i);
            if (n % 4 == 0) repeat (12) @(posedge core_clk_i);
            @(negedge core_clk_i);
            check(pb_pullup_o, eu[0]);
            check(pb_oe_o, eo[0]);
            check(pb_out_o, ev[0]);
            check(pb_ie_o, ei[0]);
            check(pc_pullup_o, eu[1]);
            check(pc_oe_o, eo[1]);
            check(pc_out_o, ev[1]);
            check(pc_ie_o, ei[1]);
            check(pd_pullup_o, eu[2]);
            check(pd_oe_o, eo[2]);
            check(pd_out_o, ev[2]);
            check(pd_ie_o, ei[2]);
            if (n % 4 == 0) begin
                check(pin_b_level_o, pin_b_i);
                check(pin_c_level_o, pin_c_i);
                check(pin_d_level_o, pin_d_i);
                check({7'h0, spi_slave_active_o}, {7'h0, spi_enable_bit_i
                      & ~spi_master_select_i & ~pin_b_i[0]});
                check(sd[20:13], pin_b_i);
                check(sd[12:5], pin_d_i & {2'h3, serial1_sync_mode_i, 5'h1f});
                check({3'h0, sd[4:0]}, {3'h0, pin_b_i[3:1], pin_d_i[2],
                      pin_d_i[0] & two_wire_enable_i});
            end
        end
        @(posedge core_clk_i);
        apply('0);
        @(posedge core_clk_i);
        two_wire_enable_i <= 1'b1;
        ext_val[1] <= 1'b1;
        repeat (12) @(posedge core_clk_i);
        ext_val[1] <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        ext_val[1] <= 1'b1;
        repeat (12) @(posedge core_clk_i);
        @(negedge core_clk_i);
        check({7'h0, sda_in_o}, 8'h01);
        @(posedge core_clk_i);
        ext_val[1] <= 1'b0;
        repeat (12) @(posedge core_clk_i);
        @(negedge core_clk_i);
        check({7'h0, sda_in_o}, 8'h00);
        test_done();
    end
endmodule : tb
`default_nettype wire
